// ### sff_map.svh
// Constants for the synchronous FIFO bank: sizes, offsets, defaults
`ifndef SFF_MAP_SVH
`define SFF_MAP_SVH

// ----------------------------------------------------------------------
// Storage geometry
// ----------------------------------------------------------------------
`define SFF_DATA_W        18
`define SFF_PTR_W         9
`define SFF_CNT_W         10
`define SFF_OFF_W         12
`define SFF_WIDE_W        13
`define SFF_DEPTH         10'h200
`define SFF_HALF_LEVEL    10'h101

// ----------------------------------------------------------------------
// Offset defaults and mode straps
// ----------------------------------------------------------------------
`define SFF_EMPTY_OFF_DEF 12'h03F
`define SFF_FULL_OFF_DEF  12'h01F
`define SFF_FALL_STRAP    3'h2
`define SFF_FALL_RISES    2'h3

// ----------------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------------
`define SFF_ADDR_W        8
`define SFF_A_CTRL        8'h00
`define SFF_A_STATUS      8'h04
`define SFF_A_IRQ_STAT    8'h08
`define SFF_A_IRQ_MASK    8'h0C
`define SFF_A_OFFSETS     8'h10
`define SFF_CTRL_FLUSH    0
`define SFF_ST_FALL       5
`define SFF_ST_CNT_LSB    16
`define SFF_OFF_FULL_LSB  16
`define SFF_IRQ_W         7
`define SFF_IRQ_FULL      0
`define SFF_IRQ_EMPTY     1
`define SFF_IRQ_AFULL     2
`define SFF_IRQ_AEMPTY    3
`define SFF_IRQ_HALF      4
`define SFF_IRQ_OVER      5
`define SFF_IRQ_UNDER     6

`endif

// ### sff_pkg.sv
// Types shared by the synchronous FIFO bank
`include "sff_map.svh"

package sff_pkg;

  // --------------------------------------------------------------------
  // Pin bundle, passed through the synchroniser as one word
  // --------------------------------------------------------------------
  typedef struct packed {
    logic                   wr_clk;
    logic                   wr_en_n;
    logic [`SFF_DATA_W-1:0] wr_data;
    logic                   rd_clk;
    logic                   rd_en_n;
    logic                   offs_n;
    logic                   load_sel;
    logic                   rd_exp;
    logic                   wr_exp;
  } sff_pins_t;

  // --------------------------------------------------------------------
  // Status flags, all active low
  // --------------------------------------------------------------------
  typedef struct packed {
    logic full_n;
    logic afull_n;
    logic half_n;
    logic aempty_n;
    logic empty_n;
  } sff_flags_t;

endpackage

// ### sff_bank.sv
// One FIFO bank: storage, flags, offsets, timing mode and APB registers
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`include "sff_map.svh"

module sff_bank (
  input  wire logic                   ref_clk,             // System clock
  input  wire logic                   rst_n,               // Sync reset
  input  wire logic                   wr_clk_pin,          // Write clock pin
  input  wire logic                   wr_en_n,             // Write enable
  input  wire logic [`SFF_DATA_W-1:0] wr_data,             // Input data
  input  wire logic                   rd_clk_pin,          // Read clock pin
  input  wire logic                   rd_en_n,             // Read enable
  input  wire logic                   offset_load_n,       // Offset access
  input  wire logic                   first_load_select,   // Mode strap
  input  wire logic                   read_expansion_in,   // Mode strap
  input  wire logic                   write_expansion_in,  // Mode strap
  output logic      [`SFF_DATA_W-1:0] rd_data,             // Output data
  output logic                        full_flag_n,         // Full
  output logic                        almost_full_flag_n,  // Almost full
  output logic                        half_full_flag_n,    // Half full
  output logic                        almost_empty_flag_n, // Almost empty
  output logic                        empty_flag_n,        // Empty
  output logic                        first_word_fall_through, // Mode
  input  wire logic                   psel,                // APB select
  input  wire logic                   penable,             // APB enable
  input  wire logic                   pwrite,              // APB direction
  input  wire logic [`SFF_ADDR_W-1:0] paddr,               // APB address
  input  wire logic [31:0]            pwdata,              // APB wdata
  output logic      [31:0]            prdata,              // APB rdata
  output logic                        pready,              // APB ready
  output logic                        pslverr,             // APB error
  output logic                        irq                  // Interrupt
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Flags from a word count and both offsets; wide sums avoid wrap
  function automatic sff_pkg::sff_flags_t calc_flags(
    input logic [`SFF_CNT_W-1:0] cnt,
    input logic [`SFF_OFF_W-1:0] eoff,
    input logic [`SFF_OFF_W-1:0] foff
  );
    sff_pkg::sff_flags_t f;
    logic [`SFF_WIDE_W-1:0] wcnt;
    wcnt    = {3'h0, cnt};
    f.empty_n  = (cnt != 10'h000);
    f.aempty_n = (wcnt > {1'b0, eoff});
    f.half_n   = (cnt < `SFF_HALF_LEVEL);
    f.afull_n  = ((wcnt + {1'b0, foff}) < {3'h0, `SFF_DEPTH});
    f.full_n   = (cnt != `SFF_DEPTH);
    return f;
  endfunction

  // --------------------------------------------------------------------
  // Pin synchroniser and edge detection
  // --------------------------------------------------------------------
  sff_pkg::sff_pins_t pins_a_reg;
  sff_pkg::sff_pins_t pins_b_reg;
  sff_pkg::sff_pins_t pins_p_reg;
  logic               wr_rise;
  logic               rd_rise;

  // Two stages per pin; data rides with its clock so they stay aligned
  always_ff @(posedge ref_clk) begin
    pins_a_reg <= '{wr_clk: wr_clk_pin, wr_en_n: wr_en_n, wr_data: wr_data,
                    rd_clk: rd_clk_pin, rd_en_n: rd_en_n,
                    offs_n: offset_load_n, load_sel: first_load_select,
                    rd_exp: read_expansion_in, wr_exp: write_expansion_in};
    pins_b_reg <= pins_a_reg;
    pins_p_reg <= pins_b_reg;
  end

  assign wr_rise = pins_b_reg.wr_clk & ~pins_p_reg.wr_clk;
  assign rd_rise = pins_b_reg.rd_clk & ~pins_p_reg.rd_clk;

  // --------------------------------------------------------------------
  // Timing mode latch
  // --------------------------------------------------------------------
  logic fall_reg;

  // Straps are followed for as long as reset is held, frozen after
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fall_reg <= ({pins_b_reg.load_sel, pins_b_reg.rd_exp,
                    pins_b_reg.wr_exp} == `SFF_FALL_STRAP);
    end
  end

  // --------------------------------------------------------------------
  // Request decode
  // --------------------------------------------------------------------
  logic                  wr_req;
  logic                  rd_req;
  logic                  offs_wr;
  logic                  offs_rd;
  logic                  push;
  logic                  pop;
  logic                  fall_load;
  logic                  flush;
  logic [`SFF_CNT_W-1:0] count_reg;
  logic [`SFF_CNT_W-1:0] count_next;
  logic                  out_valid_reg;
  logic                  out_valid_next;
  logic [1:0]            fall_cnt_reg;

  assign wr_req = wr_rise & ~pins_b_reg.wr_en_n;
  assign rd_req = rd_rise & ~pins_b_reg.rd_en_n;
  assign offs_wr = wr_req & ~pins_b_reg.offs_n;
  assign offs_rd = rd_req & ~pins_b_reg.offs_n & ~fall_reg;
  // Full storage refuses the word; nothing is overwritten
  assign push   = wr_req & pins_b_reg.offs_n
                  & (count_reg != `SFF_DEPTH);
  // Fall-through loads its empty output stage after the third read clock rise
  assign fall_load = fall_reg & (count_reg != 10'h000) & rd_rise
                     & ((~out_valid_reg
                         & ((fall_cnt_reg + 2'h1) == `SFF_FALL_RISES))
                        | (out_valid_reg & ~pins_b_reg.rd_en_n
                           & pins_b_reg.offs_n));
  // Empty storage ignores the read enable
  assign pop    = fall_load
                  | (~fall_reg & rd_req & pins_b_reg.offs_n
                     & (count_reg != 10'h000));

  // Next count and output-stage state
  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 10'h001;
    end else if (pop && !push) begin
      count_next = count_reg - 10'h001;
    end
    out_valid_next = out_valid_reg;
    if (fall_load) begin
      out_valid_next = 1'b1;
    end else if (fall_reg && out_valid_reg && rd_req
                 && pins_b_reg.offs_n) begin
      out_valid_next = 1'b0;
    end
    if (flush) begin
      count_next     = 10'h000;
      out_valid_next = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Storage and pointers
  // --------------------------------------------------------------------
  logic [`SFF_DATA_W-1:0] mem [0:`SFF_DEPTH-1];
  logic [`SFF_PTR_W-1:0]  wptr_reg;
  logic [`SFF_PTR_W-1:0]  rptr_reg;

  // Array carries no reset; only pointers define its content
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wptr_reg] <= pins_b_reg.wr_data;
    end
  end

  // Pointers wrap naturally at the power-of-two depth
  always_ff @(posedge ref_clk) begin
    if (!rst_n || flush) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 9'h001;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 9'h001;
      end
    end
  end

  // Count and fall-through sequencer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_reg     <= 10'h000;
      out_valid_reg <= 1'b0;
      fall_cnt_reg  <= 2'h0;
    end else begin
      count_reg     <= count_next;
      out_valid_reg <= out_valid_next;
      if (flush || fall_load || out_valid_reg || count_reg == 10'h000) begin
        fall_cnt_reg <= 2'h0;
      end else if (fall_reg && rd_rise) begin
        fall_cnt_reg <= fall_cnt_reg + 2'h1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Offset registers
  // --------------------------------------------------------------------
  logic [`SFF_OFF_W-1:0] empty_off_reg;
  logic [`SFF_OFF_W-1:0] full_off_reg;
  logic                  offs_wsel_reg;
  logic                  offs_rsel_reg;

  // Write sequence resumes where it stopped when load is raised
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      empty_off_reg <= `SFF_EMPTY_OFF_DEF;
      full_off_reg  <= `SFF_FULL_OFF_DEF;
      offs_wsel_reg <= 1'b0;
    end else if (offs_wr) begin
      if (!offs_wsel_reg) begin
        empty_off_reg <= pins_b_reg.wr_data[`SFF_OFF_W-1:0];
      end else begin
        full_off_reg  <= pins_b_reg.wr_data[`SFF_OFF_W-1:0];
      end
      offs_wsel_reg <= ~offs_wsel_reg;
    end
  end

  // --------------------------------------------------------------------
  // Output data stage
  // --------------------------------------------------------------------
  // Standard mode changes data only on an explicit read
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_data       <= '0;
      offs_rsel_reg <= 1'b0;
    end else if (offs_rd) begin
      rd_data       <= {6'h00, offs_rsel_reg ? full_off_reg
                                             : empty_off_reg};
      offs_rsel_reg <= ~offs_rsel_reg;
    end else if (pop) begin
      rd_data <= mem[rptr_reg];
    end
  end

  // --------------------------------------------------------------------
  // Flags
  // --------------------------------------------------------------------
  sff_pkg::sff_flags_t flags_reg;
  sff_pkg::sff_flags_t flags_next;

  // Fall-through empty flag reports a presented word instead of stored words
  always_comb begin
    flags_next = calc_flags(count_next, empty_off_reg, full_off_reg);
    if (fall_reg) begin
      flags_next.empty_n = out_valid_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags_reg <= '{full_n: 1'b1, afull_n: 1'b1, half_n: 1'b1,
                     aempty_n: 1'b0, empty_n: 1'b0};
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign full_flag_n             = flags_reg.full_n;
  assign almost_full_flag_n      = flags_reg.afull_n;
  assign half_full_flag_n        = flags_reg.half_n;
  assign almost_empty_flag_n     = flags_reg.aempty_n;
  assign empty_flag_n            = flags_reg.empty_n;
  assign first_word_fall_through = fall_reg;

  // --------------------------------------------------------------------
  // APB slave and interrupt registers
  // --------------------------------------------------------------------
  logic                  acc;
  logic                  wr_acc;
  logic                  mapped;
  logic [`SFF_IRQ_W-1:0] irq_stat_reg;
  logic [`SFF_IRQ_W-1:0] irq_mask_reg;
  logic [`SFF_IRQ_W-1:0] ev;
  logic [31:0]           rd_mux;

  // One wait state so read data always comes from a flop
  assign acc    = psel & penable & pready;
  assign wr_acc = acc & pwrite;
  assign mapped = (paddr == `SFF_A_CTRL) || (paddr == `SFF_A_STATUS)
                  || (paddr == `SFF_A_IRQ_STAT) || (paddr == `SFF_A_IRQ_MASK)
                  || (paddr == `SFF_A_OFFSETS);
  assign flush  = wr_acc & (paddr == `SFF_A_CTRL) & pwdata[`SFF_CTRL_FLUSH];

  // Asserting flag edges, refused writes and standard-mode refused reads become events
  always_comb begin
    ev = '0;
    ev[`SFF_IRQ_FULL]   = flags_reg.full_n & ~flags_next.full_n;
    ev[`SFF_IRQ_EMPTY]  = flags_reg.empty_n & ~flags_next.empty_n;
    ev[`SFF_IRQ_AFULL]  = flags_reg.afull_n & ~flags_next.afull_n;
    ev[`SFF_IRQ_AEMPTY] = flags_reg.aempty_n & ~flags_next.aempty_n;
    ev[`SFF_IRQ_HALF]   = flags_reg.half_n & ~flags_next.half_n;
    ev[`SFF_IRQ_OVER]   = wr_req & pins_b_reg.offs_n & ~push;
    ev[`SFF_IRQ_UNDER]  = ~fall_reg & rd_req & pins_b_reg.offs_n & ~pop;
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `SFF_A_STATUS: begin
        rd_mux[4:0] = flags_reg;
        rd_mux[`SFF_ST_FALL] = fall_reg;
        rd_mux[`SFF_ST_CNT_LSB +: `SFF_CNT_W] = count_reg;
      end
      `SFF_A_IRQ_STAT: rd_mux[`SFF_IRQ_W-1:0] = irq_stat_reg;
      `SFF_A_IRQ_MASK: rd_mux[`SFF_IRQ_W-1:0] = irq_mask_reg;
      `SFF_A_OFFSETS: begin
        rd_mux[`SFF_OFF_W-1:0] = empty_off_reg;
        rd_mux[`SFF_OFF_FULL_LSB +: `SFF_OFF_W] = full_off_reg;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata  <= (psel && penable && !pready && !pwrite) ? rd_mux
                                                         : 32'h0000_0000;
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq          <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg
                       & ~((wr_acc && paddr == `SFF_A_IRQ_STAT)
                           ? pwdata[`SFF_IRQ_W-1:0] : 7'h00)) | ev;
      if (wr_acc && paddr == `SFF_A_IRQ_MASK) begin
        irq_mask_reg <= pwdata[`SFF_IRQ_W-1:0];
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_mode_frozen: assert property (rst_n |=> $stable(fall_reg))
    else $error("timing mode changed outside reset");

  a_std_data_hold: assert property (
    !fall_reg && !rd_req |=> $stable(rd_data))
    else $error("standard output changed without a read");

  a_fall_first: assert property (
    fall_reg && !out_valid_reg && count_reg != 10'h000 && rd_rise
    && fall_cnt_reg == 2'h2 && !flush |=> out_valid_reg)
    else $error("first word not presented on third read rise");

  a_first_write: assert property (
    !fall_reg && count_reg == 10'h000 && push && !flush
    |=> empty_flag_n && count_reg == 10'h001)
    else $error("empty flag stayed low after first write");

  a_half_mark: assert property (
    count_reg == (`SFF_HALF_LEVEL - 10'h001) && push && !pop && !flush
    |=> !half_full_flag_n ##1 1'b1)
    else $error("half-full flag missed its threshold");

  a_almost_full: assert property (
    ({3'h0, count_reg} + {1'b0, full_off_reg}) >= {3'h0, `SFF_DEPTH}
    && $stable(full_off_reg) |-> !almost_full_flag_n)
    else $error("almost-full flag high above threshold");

  a_full_refuse: assert property (
    count_reg == `SFF_DEPTH && wr_req && !pop && !flush
    |=> count_reg == `SFF_DEPTH && !full_flag_n)
    else $error("write accepted while full");

  a_almost_empty: assert property (
    !fall_reg && {3'h0, count_reg} <= {1'b0, empty_off_reg}
    && $stable(empty_off_reg) |-> !almost_empty_flag_n)
    else $error("almost-empty flag high at or below offset");

  a_empty_ignore: assert property (
    !fall_reg && count_reg == 10'h000 && rd_req && pins_b_reg.offs_n
    && !push |=> count_reg == 10'h000 && $stable(rd_data))
    else $error("read performed while empty");

  a_offset_alt: assert property (
    offs_wr |=> offs_wsel_reg != $past(offs_wsel_reg))
    else $error("offset load sequence did not advance");

  a_reset_idle: assert property (
    $rose(rst_n) |-> count_reg == 10'h000 && full_flag_n
    && half_full_flag_n && !empty_flag_n
    && empty_off_reg == `SFF_EMPTY_OFF_DEF)
    else $error("reset did not leave an empty FIFO");

endmodule // sff_bank

// ### sff_far_end.sv
// Far-end model: writer and reader logic driving the FIFO bank pins
`include "sff_map.svh"

module sff_far_end (
  input  wire logic                   ref_clk, // Bench clock
  output logic                        wr_clk,  // Write clock pin
  output logic                        wr_en_n, // Write enable
  output logic      [`SFF_DATA_W-1:0] wr_data, // Write data
  output logic                        rd_clk,  // Read clock pin
  output logic                        rd_en_n, // Read enable
  output logic                        offs_n   // Offset access
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle levels from time zero
  initial begin
    wr_clk  = 1'b0;
    wr_en_n = 1'b1;
    wr_data = '0;
    rd_clk  = 1'b0;
    rd_en_n = 1'b1;
    offs_n  = 1'b1;
  end

  // One 400 ns link period; clock stands still between frames
  task automatic tick(input logic rd);
    repeat (4) @(posedge ref_clk);
    if (rd) rd_clk <= 1'b1;
    else wr_clk <= 1'b1;
    repeat (4) @(posedge ref_clk);
    if (rd) rd_clk <= 1'b0;
    else wr_clk <= 1'b0;
  endtask

  // Controls held over the whole rise, slow sync needs the margin
  task automatic put(input logic [`SFF_DATA_W-1:0] d, input logic ol);
    @(posedge ref_clk);
    wr_en_n <= 1'b0;
    offs_n  <= ol;
    wr_data <= d;
    tick(1'b0);
    wr_en_n <= 1'b1;
    offs_n  <= 1'b1;
    wr_data <= ~d;   // Released bus must not show the stale word
  endtask

  // Read side frame; ren high gives a bare clock pulse
  task automatic take(input logic ol, input logic ren);
    @(posedge ref_clk);
    rd_en_n <= ren;
    offs_n  <= ol;
    tick(1'b1);
    rd_en_n <= 1'b1;
    offs_n  <= 1'b1;
  endtask
endmodule // sff_far_end

// ### tb.sv
// Testbench for the FIFO bank: pins, flags, offsets, APB and interrupt
`include "sff_map.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = 5; // Programmed empty offset
  localparam int M = 9; // Programmed full offset
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel_strap = 1'b0, rexp_strap = 1'b0, wexp_strap = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic wck, wen_n, rck, ren_n, offs_n, irq, fall_mode;
  logic [`SFF_DATA_W-1:0] wd, rd;
  sff_pkg::sff_flags_t fs;
  int fails = 0, checked = 0;

  always #25 ref_clk = ~ref_clk;

  sff_far_end sff_far_end_inst (.ref_clk(ref_clk), .wr_clk(wck),
    .wr_en_n(wen_n), .wr_data(wd), .rd_clk(rck), .rd_en_n(ren_n),
    .offs_n(offs_n));
  sff_bank sff_bank_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .wr_clk_pin(wck), .wr_en_n(wen_n), .wr_data(wd), .rd_clk_pin(rck),
    .rd_en_n(ren_n), .offset_load_n(offs_n),
    .first_load_select(sel_strap), .read_expansion_in(rexp_strap),
    .write_expansion_in(wexp_strap), .rd_data(rd),
    .full_flag_n(fs.full_n), .almost_full_flag_n(fs.afull_n),
    .half_full_flag_n(fs.half_n), .almost_empty_flag_n(fs.aempty_n),
    .empty_flag_n(fs.empty_n), .first_word_fall_through(fall_mode),
    .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  // APB master: holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Flags after a pin edge land some cycles later
  task automatic check(input int c);
    repeat (3) @(posedge ref_clk);
    `CHK("flags", {c != 512, c < 512 - M, c < 257, c > N, c != 0}, fs)
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hang guard, well beyond the roughly 12500 cycles of the tests
  initial begin
    #2_000_000;
    fails++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    check(0);
    `CHK("mode", 1'b0, fall_mode)
    apb(1'b0, `SFF_A_OFFSETS, 32'h0);
    `CHK("defaults", 32'h001F_003F, rdat)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 1'b1, err)
    sff_far_end_inst.put(18'(N), 1'b0);
    sff_far_end_inst.put(18'(M), 1'b0);
    apb(1'b0, `SFF_A_OFFSETS, 32'h0);
    `CHK("offsets", 32'(M) << 16 | 32'(N), rdat)
    sff_far_end_inst.take(1'b0, 1'b0);
    check(0);
    `CHK("eoff_rd", 18'(N), rd)
    sff_far_end_inst.take(1'b0, 1'b0);
    check(0);
    `CHK("foff_rd", 18'(M), rd)
    apb(1'b1, `SFF_A_IRQ_MASK, 32'h0000_0040);
    sff_far_end_inst.take(1'b1, 1'b0);
    check(0);
    `CHK("empty_rd", 18'(M), rd)
    `CHK("irq_set", 1'b1, irq)
    apb(1'b1, `SFF_A_IRQ_STAT, 32'h0000_0040);
    repeat (3) @(posedge ref_clk);
    `CHK("irq_clr", 1'b0, irq)
    for (int i = 1; i <= 513; i++) begin
      sff_far_end_inst.put(18'(i), 1'b1);
      check(i > 512 ? 512 : i);
      if (i == 1) `CHK("no_fall", 18'(M), rd)
    end
    apb(1'b0, `SFF_A_STATUS, 32'h0);
    `CHK("count", 10'h200, rdat[25:16])
    // Half, almost-full, full and refused write all left their mark
    apb(1'b0, `SFF_A_IRQ_STAT, 32'h0);
    `CHK("irq_events", 32'h0000_0035, rdat)
    for (int i = 1; i <= 513; i++) begin
      sff_far_end_inst.take(1'b1, 1'b0);
      check(i > 512 ? 0 : 512 - i);
      `CHK("rd_data", 18'(i > 512 ? 512 : i), rd)
    end
    rst_n <= 1'b0;
    rexp_strap <= 1'b1; // Straps held through reset
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    check(0);
    `CHK("fall_mode", 1'b1, fall_mode)
    sff_far_end_inst.put(18'h1_2345, 1'b1);
    sff_far_end_inst.take(1'b1, 1'b1);
    sff_far_end_inst.take(1'b1, 1'b1);
    check(0); // Word stored but not yet presented, so still empty
    `CHK("early", 18'h0_0000, rd)
    sff_far_end_inst.take(1'b1, 1'b1);
    check(1);
    `CHK("fall", 18'h1_2345, rd)
    // Flush drops stored words and the presented one alike
    sff_far_end_inst.put(18'h0_0111, 1'b1);
    sff_far_end_inst.put(18'h0_0222, 1'b1);
    apb(1'b1, `SFF_A_CTRL, 32'h0000_0001);
    apb(1'b0, `SFF_A_STATUS, 32'h0);
    `CHK("flushed", 32'h0000_003C, rdat)
    final_report();
  end
endmodule // tb
